// File: hdl/psr_ctrl.sv
// AXI4-Lite slave holding the two peripheral soft reset control registers.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
module psr_ctrl (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] capabilities_reg_1,
  input wire logic [31:0] capabilities_reg_2,
  output psr_pkg::psr_resets_s periph_reset
);
  // ==========================================================================
  // Register state.
  logic [31:0] peripheral_reset_ctrl_0;
  logic [31:0] peripheral_reset_ctrl_1;
  logic [31:0] next_peripheral_reset_ctrl_0;
  logic [31:0] next_peripheral_reset_ctrl_1;
  logic [31:0] merged_0;
  logic [31:0] merged_1;

  // ==========================================================================
  // Write channel: address and data are latched independently, in either order.
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held;
  logic next_w_held;
  logic [11:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic do_write;

  // Ready stays low while a response is pending so one write is in flight at a time.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  psr_wmask #(.WIDTH(32)) u_mask0 (
    .cur(peripheral_reset_ctrl_0),
    .wdata(w_data),
    .wstrb(w_strb),
    .cap(capabilities_reg_1),
    .impl(psr_pkg::PSR_IMPL_0),
    .merged(merged_0)
  );

  psr_wmask #(.WIDTH(32)) u_mask1 (
    .cur(peripheral_reset_ctrl_1),
    .wdata(w_data),
    .wstrb(w_strb),
    .cap(capabilities_reg_2),
    .impl(psr_pkg::PSR_IMPL_1),
    .merged(merged_1)
  );

  // Next-state for the write path and the two registers.
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_peripheral_reset_ctrl_0 = peripheral_reset_ctrl_0;
    next_peripheral_reset_ctrl_1 = peripheral_reset_ctrl_1;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = psr_pkg::PSR_RESP_OKAY;
      unique case ({aw_addr[11:2], 2'b00})
        psr_pkg::PSR_OFF_CTRL_0: next_peripheral_reset_ctrl_0 = merged_0;
        psr_pkg::PSR_OFF_CTRL_1: next_peripheral_reset_ctrl_1 = merged_1;
        default: next_bresp = psr_pkg::PSR_RESP_SLVERR;
      endcase
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // Register stage for the write path; both control registers clear on reset.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      peripheral_reset_ctrl_0 <= psr_pkg::PSR_RESET_VALUE;
      peripheral_reset_ctrl_1 <= psr_pkg::PSR_RESET_VALUE;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      peripheral_reset_ctrl_0 <= next_peripheral_reset_ctrl_0;
      peripheral_reset_ctrl_1 <= next_peripheral_reset_ctrl_1;
    end
  end

  // ==========================================================================
  // Read channel: one cycle from address to data, held until rready.
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  assign s_axi_arready = !s_axi_rvalid;

  // Reads return the live register; reserved bits can never be set so read zero.
  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = psr_pkg::PSR_RESP_OKAY;
      unique case ({s_axi_araddr[11:2], 2'b00})
        psr_pkg::PSR_OFF_CTRL_0: next_rdata = peripheral_reset_ctrl_0 & psr_pkg::PSR_IMPL_0;
        psr_pkg::PSR_OFF_CTRL_1: next_rdata = peripheral_reset_ctrl_1 & psr_pkg::PSR_IMPL_1;
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = psr_pkg::PSR_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Register stage for the read path.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // ==========================================================================
  // Reset outputs come straight from the register bits, so they follow each write at once.
  always_comb begin
    periph_reset.pwm = peripheral_reset_ctrl_0[psr_pkg::PSR_BIT_PWM];
    periph_reset.watchdog_reset_bit = peripheral_reset_ctrl_0[psr_pkg::PSR_BIT_WDOG];
    periph_reset.comparator = peripheral_reset_ctrl_1[psr_pkg::PSR_BIT_CMP0 +: 3];
    periph_reset.gp_counter = peripheral_reset_ctrl_1[psr_pkg::PSR_BIT_TMR0 +: 3];
    periph_reset.sync_serial_0_reset_bit = peripheral_reset_ctrl_1[psr_pkg::PSR_BIT_SYNC_SERIAL_0_RESET_BIT];
    periph_reset.async_serial_0_reset_bit = peripheral_reset_ctrl_1[psr_pkg::PSR_BIT_ASP0];
  end

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_write0;
    do_write && ({aw_addr[11:2], 2'b00} == psr_pkg::PSR_OFF_CTRL_0);
  endsequence
  sequence s_write1;
    do_write && ({aw_addr[11:2], 2'b00} == psr_pkg::PSR_OFF_CTRL_1);
  endsequence

  chk_mask_ctrl0: assert property (
    s_write0 |=> ((peripheral_reset_ctrl_0 ^ $past(peripheral_reset_ctrl_0))
      & ~$past(capabilities_reg_1)) == 32'h00000000)
    else $error("ctrl0 changed a bit without capability");
  chk_mask_ctrl1: assert property (
    s_write1 |=> ((peripheral_reset_ctrl_1 ^ $past(peripheral_reset_ctrl_1))
      & ~$past(capabilities_reg_2)) == 32'h00000000)
    else $error("ctrl1 changed a bit without capability");
  chk_ctrl0_write: assert property (
    (s_write0 and (w_strb == 4'hF)) |=> peripheral_reset_ctrl_0 ==
      ((($past(w_data) & $past(capabilities_reg_1)) |
      ($past(peripheral_reset_ctrl_0) & ~$past(capabilities_reg_1))) & psr_pkg::PSR_IMPL_0))
    else $error("ctrl0 write not stored");
  chk_ctrl1_write: assert property (
    (s_write1 and (w_strb == 4'hF)) |=> peripheral_reset_ctrl_1 ==
      ((($past(w_data) & $past(capabilities_reg_2)) |
      ($past(peripheral_reset_ctrl_1) & ~$past(capabilities_reg_2))) & psr_pkg::PSR_IMPL_1))
    else $error("ctrl1 write not stored");
  chk_pwm_line: assert property (
    periph_reset.pwm == peripheral_reset_ctrl_0[20])
    else $error("pwm reset line wrong");
  chk_wdog_line: assert property (
    periph_reset.watchdog_reset_bit == peripheral_reset_ctrl_0[3])
    else $error("watchdog reset line wrong");
  chk_cmp_tmr: assert property (
    {periph_reset.comparator, periph_reset.gp_counter} ==
      {peripheral_reset_ctrl_1[26:24], peripheral_reset_ctrl_1[18:16]})
    else $error("comparator or timer reset lines wrong");
  chk_serial_lines: assert property (
    {periph_reset.sync_serial_0_reset_bit, periph_reset.async_serial_0_reset_bit} ==
      {peripheral_reset_ctrl_1[4], peripheral_reset_ctrl_1[0]})
    else $error("serial reset lines wrong");
  chk_reserved_zero: assert property (
    ((peripheral_reset_ctrl_0 & ~psr_pkg::PSR_IMPL_0) == 32'h00000000) &&
      ((peripheral_reset_ctrl_1 & ~psr_pkg::PSR_IMPL_1) == 32'h00000000))
    else $error("reserved bit set");
  chk_release_edge: assert property (
    (s_write1 and (w_strb[0] && !w_data[0] && capabilities_reg_2[0]))
      |=> !periph_reset.async_serial_0_reset_bit)
    else $error("serial port not released after clear");
  chk_read_lat: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");

  // ==========================================================================
  // Bus protocol checks.
  // Answers must stand until taken, or a slow master would lose its response.
  sequence s_bresp_waiting;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  sequence s_rdata_waiting;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  sequence s_both_held;
    aw_held && w_held && !s_axi_bvalid;
  endsequence
  sequence s_write_unmapped;
    do_write && ({aw_addr[11:2], 2'b00} != psr_pkg::PSR_OFF_CTRL_0) &&
      ({aw_addr[11:2], 2'b00} != psr_pkg::PSR_OFF_CTRL_1);
  endsequence
  sequence s_read_ctrl0;
    s_axi_arvalid && s_axi_arready &&
      ({s_axi_araddr[11:2], 2'b00} == psr_pkg::PSR_OFF_CTRL_0);
  endsequence
  sequence s_read_ctrl1;
    s_axi_arvalid && s_axi_arready &&
      ({s_axi_araddr[11:2], 2'b00} == psr_pkg::PSR_OFF_CTRL_1);
  endsequence
  sequence s_read_unmapped;
    s_axi_arvalid && s_axi_arready &&
      ({s_axi_araddr[11:2], 2'b00} != psr_pkg::PSR_OFF_CTRL_0) &&
      ({s_axi_araddr[11:2], 2'b00} != psr_pkg::PSR_OFF_CTRL_1);
  endsequence

  chk_bresp_hold: assert property (
    s_bresp_waiting |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  chk_rdata_hold: assert property (
    s_rdata_waiting |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped before rready");
  chk_write_lat: assert property (
    s_both_held |=> s_axi_bvalid)
    else $error("write answer late");
  chk_one_write: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  chk_read_refuse: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  chk_unmapped_store: assert property (
    s_write_unmapped |=> $stable(peripheral_reset_ctrl_0) &&
      $stable(peripheral_reset_ctrl_1) && (s_axi_bresp == psr_pkg::PSR_RESP_SLVERR))
    else $error("unmapped write stored or not refused");
  chk_read_unmapped: assert property (
    s_read_unmapped |=>
      (s_axi_rdata == 32'h00000000) &&
      (s_axi_rresp == psr_pkg::PSR_RESP_SLVERR))
    else $error("unmapped read not refused");
  chk_read_ctrl0: assert property (
    s_read_ctrl0 |=> s_axi_rdata == $past(peripheral_reset_ctrl_0))
    else $error("ctrl0 read data wrong");
  chk_read_ctrl1: assert property (
    s_read_ctrl1 |=> s_axi_rdata == $past(peripheral_reset_ctrl_1))
    else $error("ctrl1 read data wrong");
  chk_idle_keep: assert property (
    !do_write |=> $stable(peripheral_reset_ctrl_0) && $stable(peripheral_reset_ctrl_1))
    else $error("control register changed without a write");
endmodule // psr_ctrl

// File: hdl/psr_pkg.sv
// Package of offsets, field positions and reset values for the peripheral soft reset control.
package psr_pkg;
  // ==========================================================================
  // Register map.
  localparam logic [31:0] PSR_BASE = 32'h400FE000;
  localparam logic [11:0] PSR_OFF_CTRL_0 = 12'h040;
  localparam logic [11:0] PSR_OFF_CTRL_1 = 12'h044;
  localparam logic [31:0] PSR_RESET_VALUE = 32'h00000000;
  // ==========================================================================
  // Implemented bits of each register; everything else is reserved.
  localparam logic [31:0] PSR_IMPL_0 = 32'h00100008;
  localparam logic [31:0] PSR_IMPL_1 = 32'h07070011;
  // Field positions.
  localparam int PSR_BIT_PWM = 20;
  localparam int PSR_BIT_WDOG = 3;
  localparam int PSR_BIT_CMP0 = 24;
  localparam int PSR_BIT_TMR0 = 16;
  localparam int PSR_BIT_SYNC_SERIAL_0_RESET_BIT = 4;
  localparam int PSR_BIT_ASP0 = 0;
  // AXI4-Lite response codes.
  localparam logic [1:0] PSR_RESP_OKAY = 2'h0;
  localparam logic [1:0] PSR_RESP_SLVERR = 2'h2;

  // Per-peripheral reset lines, gathered for the consumer side.
  typedef struct packed {
    logic pwm;
    logic watchdog_reset_bit;
    logic [2:0] comparator;
    logic [2:0] gp_counter;
    logic sync_serial_0_reset_bit;
    logic async_serial_0_reset_bit;
  } psr_resets_s;
endpackage

// File: hdl/psr_wmask.sv
// Masked byte-lane write merge for one reset control register.
`timescale 1ns/1ps
module psr_wmask #(
  parameter int WIDTH = 32
) (
  input wire logic [WIDTH-1:0] cur,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [WIDTH/8-1:0] wstrb,
  input wire logic [WIDTH-1:0] cap,
  input wire logic [WIDTH-1:0] impl,
  output logic [WIDTH-1:0] merged
);
  // Strobes cover whole bytes only, so a ragged or sub-byte width cannot be served.
  if ((WIDTH < 8) || (WIDTH % 8 != 0)) begin : g_bad_width
    $error("psr_wmask width must be whole bytes");
  end

  // Only bits that are strobed, implemented and present may change; the rest keep their current value.
  always_comb begin
    merged = cur;
    for (int i = 0; i < WIDTH; i++) begin
      if (wstrb[i/8] && cap[i] && impl[i]) begin
        merged[i] = wdata[i];
      end
    end
  end
endmodule // psr_wmask

// File: dv/psr_ctrl_tb.sv
// Self-checking testbench for the peripheral soft reset control slave.
`timescale 1ns/1ps
module psr_ctrl_tb;
  // ==========================================================================
  // Signals and design instance.
  logic mclk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, cap1, cap2;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  psr_pkg::psr_resets_s prst;
  int miscompares, n_tests;

  psr_ctrl DUT (.mclk(mclk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .capabilities_reg_1(cap1), .capabilities_reg_2(cap2), .periph_reset(prst));

  // The clock toggles every half period of 5 ns.
  always #5 mclk = ~mclk;

  // ==========================================================================
  // Comparison, bus cycles and verdict.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Address and data are released separately, since the slave may take them at different edges.
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    bit ap, wp;
    ap = 1;
    wp = 1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (ap || wp) begin
      @(posedge mclk);
      ap = ap && !awready;
      wp = wp && !wready;
      awvalid <= ap;
      wvalid <= wp;
    end
    do @(posedge mclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr_ok(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [1:0] r;
    axi_wr(a, d, s, r);
    check({30'h0, r}, {30'h0, psr_pkg::PSR_RESP_OKAY});
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    check(d, exp);
    check({30'h0, r}, {30'h0, psr_pkg::PSR_RESP_OKAY});
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios.
  // Reserved bits must stay zero even with every capability present; a reset mid-run clears all.
  task automatic t_full;
    rd_chk(12'h040, 32'h00000000);
    rd_chk(12'h044, 32'h00000000);
    wr_ok(12'h040, 32'hFFFFFFFF, 4'hF);
    rd_chk(12'h040, 32'h00100008);
    check({22'h0, prst}, 32'h00000300);
    wr_ok(12'h044, 32'hFFFFFFFF, 4'hF);
    rd_chk(12'h044, 32'h07070011);
    check({22'h0, prst}, 32'h000003FF);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    check({22'h0, prst}, 32'h00000000);
    nrst <= 1'b1;
    @(posedge mclk);
    rd_chk(12'h040, 32'h00000000);
    rd_chk(12'h044, 32'h00000000);
    $display("test full done");
  endtask

  // Absent peripherals keep their old bit whatever is written.
  task automatic t_mask;
    wr_ok(12'h040, 32'hFFFFFFFF, 4'hF);
    wr_ok(12'h044, 32'hFFFFFFFF, 4'hF);
    cap1 <= 32'h00000008;
    cap2 <= 32'h01010001;
    wr_ok(12'h040, 32'h00000000, 4'hF);
    wr_ok(12'h044, 32'h00000000, 4'hF);
    rd_chk(12'h040, 32'h00100000);
    rd_chk(12'h044, 32'h06060010);
    check({22'h0, prst}, 32'h000002DA);
    cap1 <= 32'hFFFFFFFF;
    cap2 <= 32'hFFFFFFFF;
    wr_ok(12'h040, 32'h00000000, 4'hF);
    wr_ok(12'h044, 32'h00000000, 4'hF);
    check({22'h0, prst}, 32'h00000000);
    $display("test mask done");
  endtask

  // Each control bit alone drives exactly its own peripheral reset line.
  task automatic t_bits;
    int pos[10] = '{20, 3, 26, 25, 24, 18, 17, 16, 4, 0};
    logic [11:0] a;
    for (int i = 0; i < 10; i++) begin
      a = (i < 2) ? 12'h040 : 12'h044;
      wr_ok(a, 32'h1 << pos[i], 4'hF);
      rd_chk(a, 32'h1 << pos[i]);
      check({22'h0, prst}, 32'h200 >> i);
      wr_ok(a, 32'h0, 4'hF);
    end
    $display("test bits done");
  endtask

  // Byte lanes, then an unmapped address that must store nothing.
  task automatic t_lanes_unmapped;
    logic [31:0] d;
    logic [1:0] r;
    wr_ok(12'h044, 32'hFFFFFFFF, 4'h1);
    rd_chk(12'h044, 32'h00000011);
    wr_ok(12'h044, 32'hFFFFFFFF, 4'h4);
    rd_chk(12'h044, 32'h00070011);
    axi_wr(12'h048, 32'hFFFFFFFF, 4'hF, r);
    check({30'h0, r}, {30'h0, psr_pkg::PSR_RESP_SLVERR});
    axi_rd(12'h048, d, r);
    check(d, 32'h00000000);
    check({30'h0, r}, {30'h0, psr_pkg::PSR_RESP_SLVERR});
    rd_chk(12'h040, 32'h00000000);
    $display("test lanes and unmapped done");
  endtask

  // Inputs start defined; reset is held for four cycles before the first request.
  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    cap1 = 32'hFFFFFFFF;
    cap2 = 32'hFFFFFFFF;
    miscompares = 0;
    n_tests = 0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_full;
    t_mask;
    t_bits;
    t_lanes_unmapped;
    summarize;
  end

  // The tests need well under a thousand cycles, so this limit only trips on a hang.
  initial begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    summarize;
  end
endmodule // psr_ctrl_tb
